// ### tpsc_bank.sv
// Per-channel transmit pulse-shape register bank with Wishbone slave.
// Assumes classic Wishbone, one clock, synchronous active-high reset.
// Functional notes
// R1: Selector 0000 gives E1 75 ohm template
// R2: Selector 0001 gives other E1 template
// R3: Selector 1XXX uses arbitrary waveform samples
// R4: Scale code 100001 means unscaled amplitude
// R5: Each code step scales three percent
// R6: Scaling spans plus to minus hundred percent
// R7: Scale code resets to 110110
// R8: Access enable works only in arbitrary mode
// R9: Direction zero writes, one reads RAM
// R10: Index 0 to 18 addresses directly
// R11: Index 19 and above hits location 19
// R12: Access controls ignored outside arbitrary mode; code latches them and a pending enable fires on entering arbitrary mode
// R13: Sample value register holds written sample
// R14: Enabled read returns stored sample
// R15: Software sets index, data, then enable
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/10ps
module tpsc_bank #(
	parameter int DEPTH = tpsc_pkg::RAM_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [tpsc_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [tpsc_pkg::DATA_W-1:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [tpsc_pkg::IDX_W-1:0] play_index,
	output logic [tpsc_pkg::DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [1:0] shape_mode,
	output logic [7:0] gain_pct,
	output logic gain_negative,
	output logic [tpsc_pkg::SAMPLE_W-1:0] arb_sample
);
	typedef enum logic [2:0] {
		TPSC_IDLE = 3'b001,
		TPSC_WAIT = 3'b010,
		TPSC_ACK = 3'b100
	} tpsc_state_t;

	tpsc_state_t state;
	tpsc_state_t next_state;
	logic [tpsc_pkg::SEL_W-1:0] template_sel;
	logic [tpsc_pkg::SCALE_W-1:0] scale_code;
	logic access_ena;
	logic access_dir;
	logic [tpsc_pkg::IDX_W-1:0] sample_index;
	logic [tpsc_pkg::SAMPLE_W-1:0] sample_value;
	logic arb_mode;
	logic req;
	logic wr_lane0;
	logic [tpsc_pkg::ADDR_W-1:0] reg_idx;
	logic ram_wr;
	logic ram_rd;
	logic [tpsc_pkg::SAMPLE_W-1:0] ram_rd_data;
	logic ram_rd_valid;
	logic [tpsc_pkg::SAMPLE_W-1:0] ram_play;
	logic [31:0] rd_mux;
	logic [7:0] next_gain;
	logic next_neg;

	assign arb_mode = template_sel[tpsc_pkg::SEL_ARB_BIT]; // R3
	assign req = wb_cyc_i && wb_stb_i && (state == TPSC_IDLE);
	assign reg_idx = {2'b00, wb_adr_i[tpsc_pkg::ADDR_W-1:2]};
	assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
	// One-shot access strobes, only in arbitrary mode
	assign ram_wr = access_ena && arb_mode && !access_dir; // R8 R9 R12
	assign ram_rd = access_ena && arb_mode && access_dir; // R8 R9 R12

	// Answer two cycles after request; ack drops the next cycle
	always_comb
	begin
		next_state = state;
		unique case (state)
			TPSC_IDLE:
			begin
				if (wb_cyc_i && wb_stb_i)
				begin
					next_state = TPSC_WAIT;
				end
			end
			TPSC_WAIT:
			begin
				next_state = TPSC_ACK;
			end
			TPSC_ACK:
			begin
				next_state = TPSC_IDLE;
			end
			default:
			begin
				next_state = TPSC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= TPSC_IDLE;
			wb_ack_o <= 1'b0;
		end
		else
		begin
			state <= next_state;
			wb_ack_o <= (next_state == TPSC_ACK);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			template_sel <= tpsc_pkg::SEL_RST;
			scale_code <= tpsc_pkg::SCALE_RST; // R7
		end
		else if (wr_lane0)
		begin
			if (reg_idx == tpsc_pkg::TEMPLATE_SEL_IDX)
			begin
				template_sel <= wb_dat_i[tpsc_pkg::SEL_W-1:0];
			end
			if (reg_idx == tpsc_pkg::AMPL_SCALE_IDX)
			begin
				scale_code <= wb_dat_i[tpsc_pkg::SCALE_W-1:0];
			end
		end
	end

	// Enable self-clears after one access
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			access_ena <= 1'b0; // R8
			access_dir <= 1'b0;
			sample_index <= '0;
		end
		else if (wr_lane0 && reg_idx == tpsc_pkg::RAM_ACCESS_IDX)
		begin
			access_ena <= wb_dat_i[tpsc_pkg::ENA_BIT];
			access_dir <= wb_dat_i[tpsc_pkg::DIR_BIT];
			sample_index <= wb_dat_i[tpsc_pkg::IDX_W-1:0]; // R10 R15
		end
		else if (ram_wr || ram_rd)
		begin
			access_ena <= 1'b0;
		end
	end

	// Software write wins over readback capture
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sample_value <= tpsc_pkg::SAMPLE_RST;
		end
		else if (wr_lane0 && reg_idx == tpsc_pkg::SAMPLE_DATA_IDX)
		begin
			sample_value <= wb_dat_i[tpsc_pkg::SAMPLE_W-1:0]; // R13
		end
		else if (ram_rd_valid)
		begin
			sample_value <= ram_rd_data; // R14
		end
	end

	tpsc_wave_ram #(
		.DEPTH(DEPTH)
	) u_ram (
		.clk(clk),
		.rst(rst),
		.wr_en(ram_wr),
		.rd_en(ram_rd),
		.index(sample_index),
		.wr_data(sample_value),
		.play_index(play_index),
		.rd_data(ram_rd_data),
		.rd_valid(ram_rd_valid),
		.play_data(ram_play)
	);

	always_comb
	begin
		rd_mux = 32'h0;
		unique case (reg_idx)
			tpsc_pkg::TEMPLATE_SEL_IDX: rd_mux = {28'h0, template_sel};
			tpsc_pkg::AMPL_SCALE_IDX: rd_mux = {26'h0, scale_code};
			tpsc_pkg::RAM_ACCESS_IDX: rd_mux = {25'h0, access_ena, access_dir, sample_index};
			tpsc_pkg::SAMPLE_DATA_IDX: rd_mux = {25'h0, sample_value};
			tpsc_pkg::SHAPE_STATUS_IDX: rd_mux = {30'h0, shape_mode};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wb_dat_o <= 32'h0;
		end
		else if (next_state == TPSC_ACK)
		begin
			wb_dat_o <= rd_mux;
		end
	end

	// Gain: percent offset from nominal, 3 per code step, saturated at 100
	always_comb
	begin
		next_neg = scale_code < tpsc_pkg::SCALE_NOMINAL; // R4
		if (next_neg)
		begin
			next_gain = 8'((tpsc_pkg::SCALE_NOMINAL - scale_code) * tpsc_pkg::STEP_PCT); // R5
		end
		else
		begin
			next_gain = 8'((scale_code - tpsc_pkg::SCALE_NOMINAL) * tpsc_pkg::STEP_PCT); // R5
		end
		if (next_gain > 8'(tpsc_pkg::SPAN_PCT))
		begin
			next_gain = 8'(tpsc_pkg::SPAN_PCT); // R6
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			shape_mode <= tpsc_pkg::MODE_E1_75;
			gain_pct <= 8'h00;
			gain_negative <= 1'b0;
			arb_sample <= tpsc_pkg::SAMPLE_RST;
		end
		else
		begin
			gain_pct <= next_gain;
			gain_negative <= next_neg;
			arb_sample <= arb_mode ? ram_play : tpsc_pkg::SAMPLE_RST; // R3
			if (arb_mode)
			begin
				shape_mode <= tpsc_pkg::MODE_ARB; // R3
			end
			else if (template_sel == tpsc_pkg::SEL_E1_75)
			begin
				shape_mode <= tpsc_pkg::MODE_E1_75; // R1
			end
			else if (template_sel == tpsc_pkg::SEL_E1_OTHER)
			begin
				shape_mode <= tpsc_pkg::MODE_E1_OTHER; // R2
			end
			else
			begin
				shape_mode <= tpsc_pkg::MODE_OFF;
			end
		end
	end

	sequence s_req;
		wb_cyc_i && wb_stb_i && state == TPSC_IDLE;
	endsequence
	sequence s_ack_then_drop;
		!wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o ##1 !wb_ack_o;
	endsequence

	property p_bus_ack;
		@(posedge clk) disable iff (rst)
		s_req |-> s_ack_then_drop;
	endproperty
	a_bus_ack: assert property (p_bus_ack) else $error("ack timing wrong");

	property p_mode_arb;
		@(posedge clk) disable iff (rst)
		arb_mode |=> shape_mode == tpsc_pkg::MODE_ARB;
	endproperty
	a_mode_arb: assert property (p_mode_arb) else $error("arb mode not chosen"); // R3

	property p_mode_75;
		@(posedge clk) disable iff (rst)
		template_sel == tpsc_pkg::SEL_E1_75 |=> shape_mode == tpsc_pkg::MODE_E1_75;
	endproperty
	a_mode_75: assert property (p_mode_75) else $error("75 ohm template not chosen"); // R1

	property p_mode_other;
		@(posedge clk) disable iff (rst)
		template_sel == tpsc_pkg::SEL_E1_OTHER |=> shape_mode == tpsc_pkg::MODE_E1_OTHER;
	endproperty
	a_mode_other: assert property (p_mode_other) else $error("other template not chosen"); // R2

	property p_nominal;
		@(posedge clk) disable iff (rst)
		scale_code == tpsc_pkg::SCALE_NOMINAL |=> gain_pct == 8'h00 && !gain_negative;
	endproperty
	a_nominal: assert property (p_nominal) else $error("nominal code scaled"); // R4

	property p_step;
		@(posedge clk) disable iff (rst)
		scale_code == 6'h22 |=> gain_pct == 8'h03 && !gain_negative;
	endproperty
	a_step: assert property (p_step) else $error("step not three percent"); // R5

	property p_span;
		@(posedge clk) disable iff (rst)
		1'b1 |=> gain_pct <= 8'h64;
	endproperty
	a_span: assert property (p_span) else $error("gain beyond span"); // R6

	property p_ignore;
		@(posedge clk) disable iff (rst)
		!arb_mode |-> !ram_wr && !ram_rd;
	endproperty
	a_ignore: assert property (p_ignore) else $error("access outside arb mode"); // R12

	property p_readback;
		@(posedge clk) disable iff (rst)
		ram_rd && !(wr_lane0 && reg_idx == tpsc_pkg::SAMPLE_DATA_IDX) ##1
			!(wr_lane0 && reg_idx == tpsc_pkg::SAMPLE_DATA_IDX)
			|=> sample_value == $past(ram_rd_data);
	endproperty
	a_readback: assert property (p_readback) else $error("readback not captured"); // R14

	property p_hold;
		@(posedge clk) disable iff (rst)
		!wr_lane0 && !ram_rd_valid |=> $stable(sample_value);
	endproperty
	a_hold: assert property (p_hold) else $error("sample value changed"); // R13
endmodule

// ### tpsc_pkg.sv
// Package for the transmit pulse-shape configuration bank.
// Assumes a Wishbone slave with 32-bit data and byte addressing.
package tpsc_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// Register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] TEMPLATE_SEL_IDX = 12'h006;
	localparam logic [ADDR_W-1:0] AMPL_SCALE_IDX = 12'h007;
	localparam logic [ADDR_W-1:0] RAM_ACCESS_IDX = 12'h008;
	localparam logic [ADDR_W-1:0] SAMPLE_DATA_IDX = 12'h009;
	localparam logic [ADDR_W-1:0] SHAPE_STATUS_IDX = 12'h00A;
	// Field layout
	localparam int SEL_W = 4;
	localparam int SEL_ARB_BIT = 3;
	localparam int SCALE_W = 6;
	localparam int IDX_W = 5;
	localparam int ENA_BIT = 6;
	localparam int DIR_BIT = 5;
	localparam int SAMPLE_W = 7;
	localparam int RAM_DEPTH = 20;
	localparam int RAM_AW = 5;
	localparam logic [IDX_W-1:0] LAST_SAMPLE = 5'h13;
	// Template codes
	localparam logic [SEL_W-1:0] SEL_E1_75 = 4'h0;
	localparam logic [SEL_W-1:0] SEL_E1_OTHER = 4'h1;
	// Reset values and nominal scale code
	localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
	localparam logic [SCALE_W-1:0] SCALE_RST = 6'h36;
	localparam logic [SCALE_W-1:0] SCALE_NOMINAL = 6'h21;
	localparam logic [7:0] ACCESS_RST = 8'h00;
	localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 7'h00;
	// Amplitude step in percent per code
	localparam int STEP_PCT = 3;
	localparam int SPAN_PCT = 100;
	// Shape modes, including off
	localparam logic [1:0] MODE_E1_75 = 2'h0;
	localparam logic [1:0] MODE_E1_OTHER = 2'h1;
	localparam logic [1:0] MODE_ARB = 2'h2;
	localparam logic [1:0] MODE_OFF = 2'h3;
endpackage

// ### tpsc_wave_ram.sv
// Sample memory for the arbitrary waveform, with index clamp.
// Assumes single-cycle strobes from the register bank on the same clock.
`timescale 1ns/10ps
module tpsc_wave_ram #(
	parameter int DEPTH = tpsc_pkg::RAM_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [tpsc_pkg::IDX_W-1:0] index,
	input wire logic [tpsc_pkg::SAMPLE_W-1:0] wr_data,
	input wire logic [tpsc_pkg::IDX_W-1:0] play_index,
	output logic [tpsc_pkg::SAMPLE_W-1:0] rd_data,
	output logic rd_valid,
	output logic [tpsc_pkg::SAMPLE_W-1:0] play_data
);
	logic [tpsc_pkg::SAMPLE_W-1:0] mem [DEPTH];
	logic [tpsc_pkg::RAM_AW-1:0] loc;
	logic [tpsc_pkg::RAM_AW-1:0] play_loc;

	// Codes beyond the last location fold onto it
	always_comb
	begin
		loc = (index > tpsc_pkg::LAST_SAMPLE) ? tpsc_pkg::LAST_SAMPLE : index; // R10 R11
		play_loc = (play_index > tpsc_pkg::LAST_SAMPLE) ? tpsc_pkg::LAST_SAMPLE : play_index;
	end

	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem[loc] <= wr_data; // R9
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rd_data <= tpsc_pkg::SAMPLE_RST;
			rd_valid <= 1'b0;
		end
		else
		begin
			rd_valid <= rd_en;
			if (rd_en)
			begin
				rd_data <= mem[loc]; // R14
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			play_data <= tpsc_pkg::SAMPLE_RST;
		end
		else
		begin
			play_data <= mem[play_loc];
		end
	end

	property p_clamp;
		@(posedge clk) disable iff (rst)
		(index > tpsc_pkg::LAST_SAMPLE) |-> (loc == tpsc_pkg::LAST_SAMPLE);
	endproperty
	a_clamp: assert property (p_clamp) else $error("index not clamped to 19"); // R11
endmodule

// ### tb_tpsc_bank.sv
// Self-checking bench for the transmit pulse-shape register bank.
// Assumes the bank answers classic Wishbone with ack two cycles after a request.
`timescale 1ns/10ps
module tb_tpsc_bank;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [31:0] dat = 32'h00000000;
	logic [3:0] sel = 4'h0;
	logic [4:0] play_index = 5'h00;
	logic [31:0] dat_o;
	logic ack;
	logic [1:0] mode;
	logic [7:0] gain;
	logic neg;
	logic [6:0] play_out;
	logic [31:0] v;
	int num_errors = 0;
	int n_compared = 0;

	tpsc_bank i_tpsc_bank (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
		.play_index(play_index), .wb_dat_o(dat_o), .wb_ack_o(ack), .shape_mode(mode),
		.gain_pct(gain), .gain_negative(neg), .arb_sample(play_out));

	always #5 clk = ~clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One classic cycle; waits for ack, watchdog ends a hang
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do
		begin
			@(posedge clk);
		end while (ack !== 1'b1);
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, 4'h1, r);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h00000000, 4'hF, r);
	endtask

	// Load one sample: value, then index with enable
	task automatic put(input logic [4:0] idx, input logic [6:0] val);
		wr(12'h024, {25'h0000000, val});
		wr(12'h020, {24'h000000, 3'h2, idx});
	endtask

	task automatic get(input logic [4:0] idx, output logic [31:0] r);
		wr(12'h020, {24'h000000, 3'h3, idx});
		rd(12'h024, r);
	endtask

	task automatic t_reset();
		rd(12'h01C, v);
		chk(v, 32'h00000036);
		rd(12'h020, v);
		chk(v, 32'h00000000);
		chk({24'h000000, gain}, 32'h0000003F);
		chk({31'h00000000, neg}, 32'h00000000);
		rd(12'h100, v);
		chk(v, 32'h00000000);
		$display("test reset done");
	endtask

	task automatic t_scale();
		logic [5:0] codes [5] = '{6'h21, 6'h22, 6'h20, 6'h00, 6'h3F};
		logic [7:0] pct [5] = '{8'h00, 8'h03, 8'h03, 8'h63, 8'h5A};
		logic sgn [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
		for (int i = 0; i < 5; i++)
		begin
			wr(12'h01C, {26'h0000000, codes[i]});
			rd(12'h01C, v);
			chk(v, {26'h0000000, codes[i]});
			chk({24'h000000, gain}, {24'h000000, pct[i]});
			chk({31'h00000000, neg}, {31'h00000000, sgn[i]});
		end
		// Byte lane 0 disabled: write ignored
		bus(1'b1, 12'h01C, 32'h00000010, 4'hE, v);
		rd(12'h01C, v);
		chk(v, 32'h0000003F);
		$display("test scale done");
	endtask

	task automatic t_template();
		logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h5, 4'h8, 4'hF};
		logic [1:0] modes [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h2};
		for (int i = 0; i < 5; i++)
		begin
			wr(12'h018, {28'h0000000, codes[i]});
			chk({30'h00000000, mode}, {30'h00000000, modes[i]});
			rd(12'h028, v);
			chk(v, {30'h00000000, modes[i]});
		end
		$display("test template done");
	endtask

	task automatic t_ram();
		// Data set first, then index and direction in the same write as enable
		put(5'h00, 7'h55);
		put(5'h12, 7'h2A);
		put(5'h13, 7'h7E);
		rd(12'h020, v);
		chk(v, 32'h00000013);
		get(5'h00, v);
		chk(v, 32'h00000055);
		get(5'h12, v);
		chk(v, 32'h0000002A);
		get(5'h1F, v);
		chk(v, 32'h0000007E);
		rd(12'h024, v);
		chk(v, 32'h0000007E);
		play_index <= 5'h12;
		repeat (4) @(posedge clk);
		chk({25'h0000000, play_out}, 32'h0000002A);
		$display("test ram done");
	endtask

	task automatic t_ignore();
		wr(12'h018, 32'h00000001);
		chk({25'h0000000, play_out}, 32'h00000000);
		wr(12'h024, 32'h00000011);
		wr(12'h020, 32'h00000060);
		repeat (3) @(posedge clk);
		rd(12'h024, v);
		chk(v, 32'h00000011);
		wr(12'h018, 32'h00000008);
		repeat (3) @(posedge clk);
		rd(12'h024, v);
		chk(v, 32'h00000055);
		rd(12'h020, v);
		chk(v, 32'h00000020);
		$display("test ignore done");
	endtask

	task automatic complete_run();
		$display("compared=%0d errors=%0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		#200000;
		num_errors++;
		complete_run();
	end

	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_scale();
		t_template();
		t_ram();
		t_ignore();
		complete_run();
	end
endmodule
